/* File: logic/fspc_entry_detect.sv */
`timescale 1ns/1ps
module fspc_entry_detect
  import fspc_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic i_serial_clk,
  input wire logic i_tool_reset,
  output logic o_comm_mode,
  output logic o_tool_attached
);
  import fspc_pkg::*;

  logic [1:0] clk_sync_q;
  logic [1:0] clk_sync_d;
  logic [1:0] rst_sync_q;
  logic [1:0] rst_sync_d;
  logic clk_prev_q;
  logic clk_prev_d;
  logic [5:0] count_q;
  logic [5:0] count_d;
  logic mode_q;
  logic mode_d;
  logic attached_q;
  logic attached_d;

  always_comb
  begin
    clk_sync_d = {clk_sync_q[0], i_serial_clk};
    rst_sync_d = {rst_sync_q[0], i_tool_reset};
    clk_prev_d = clk_sync_q[1];
    count_d = count_q;
    mode_d = mode_q;
    attached_d = attached_q;
    if (rst_sync_q[1])
    begin
      // Pulses are counted only while the tool holds reset; leaving it ends the count.
      attached_d = 1'b1;
      if (clk_sync_q[1] && !clk_prev_q && count_q != FSPC_ENTRY_PULSES)
      begin
        count_d = count_q + 6'd1;
      end
    end
    else
    begin
      if (count_q == FSPC_ENTRY_PULSES)
      begin
        mode_d = 1'b1;
      end
      count_d = 6'd0;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      clk_sync_q <= 2'b00;
      rst_sync_q <= 2'b00;
      clk_prev_q <= 1'b0;
      count_q <= 6'd0;
      mode_q <= 1'b0;
      attached_q <= 1'b0;
    end
    else if (i_ce)
    begin
      clk_sync_q <= clk_sync_d;
      rst_sync_q <= rst_sync_d;
      clk_prev_q <= clk_prev_d;
      count_q <= count_d;
      mode_q <= mode_d;
      attached_q <= attached_d;
    end
  end

  assign o_comm_mode = mode_q;
  assign o_tool_attached = attached_q;

endmodule // fspc_entry_detect

/* File: logic/fspc_pkg.sv */
package fspc_pkg;

  // Register map. The printed offset 0x0029 is not a multiple of four, so it is an index.
  localparam logic [7:0] FSPC_IDX_FCTL = 8'h29;
  localparam logic [7:0] FSPC_IDX_OPER = 8'h2A;
  localparam logic [7:0] FSPC_IDX_STAT = 8'h2B;
  localparam logic [7:0] FSPC_IDX_GUARD = 8'h2C;
  localparam logic [7:0] FSPC_IDX_SIZE = 8'h2D;

  localparam logic [7:0] FSPC_CTRL_RST = 8'h00;
  localparam logic [7:0] FSPC_GUARD_KEY1 = 8'h56;
  localparam logic [7:0] FSPC_GUARD_KEY2 = 8'hAE;

  // Operation register fields.
  localparam int FSPC_OP_CMD_LSB = 0;
  localparam int FSPC_OP_ADDR_LSB = 8;
  localparam int FSPC_OP_DATA_LSB = 24;

  // Sector 0 is F000h-FFFFh, sector 1 is E000h-EFFFh, sector 2 is the rest.
  localparam logic [15:0] FSPC_SEC0_BASE = 16'hF000;
  localparam logic [15:0] FSPC_SEC1_BASE = 16'hE000;
  localparam int FSPC_SEC_BYTES = 4096;
  localparam logic [15:0] FSPC_MEM_TOP = 16'hFFFF;

  // Flash size codes.
  localparam logic [1:0] FSPC_SIZE_4K = 2'd0;
  localparam logic [1:0] FSPC_SIZE_8K = 2'd1;
  localparam logic [1:0] FSPC_SIZE_BIG = 2'd2;

  // Link entry: number of clock pulses while reset is held.
  localparam logic [5:0] FSPC_ENTRY_PULSES = 6'd36;

  typedef enum logic [2:0]
  {
    FSPC_CMD_NONE = 3'b000,
    FSPC_CMD_PROG = 3'b001,
    FSPC_CMD_SECT = 3'b010,
    FSPC_CMD_BULK = 3'b011,
    FSPC_CMD_PROT = 3'b100,
    FSPC_CMD_UNPROT = 3'b101
  } fspc_cmd_t;

  typedef enum logic [1:0]
  {
    FSPC_MODE_IAP = 2'b00,
    FSPC_MODE_ICP = 2'b01,
    FSPC_MODE_TOOL = 2'b10
  } fspc_mode_t;

endpackage

/* File: logic/fspc_top.sv */
// Summary of operation
// - Byte program, sector erase, whole erase.
// - Up to three sectors, erased independently.
// - Sectors zero and one are 4K, topmost.
// - Sector zero is F000h-FFFFh, holds vectors.
// - Sectors present follow the flash size.
// - Protection blocks external reads and writes.
// - Removing protection first erases whole array.
// - One option bit holds protection state.
// - Application mode cannot touch sector zero.
// - Tool and circuit modes reach everything.
// - Thirty-six pulse sequence enters comm mode.
// - Link is serial clock plus data.
// - Attached tool takes link pins from application.
// - Eight-bit control register, resets to zero.
// - Key guard prevents accidental program or erase.
`timescale 1ns/1ps
module fspc_top
  import fspc_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] i_flash_size,
  input wire logic i_tool_socket,
  input wire logic i_ext_read_req,
  input wire logic [15:0] i_ext_read_addr,
  output logic [7:0] o_ext_read_data,
  input wire logic i_prog_serial_clock,
  input wire logic i_tool_reset,
  input wire logic i_prog_serial_data,
  output logic o_prog_serial_data,
  output logic o_prog_serial_data_oe,
  input wire logic i_app_data_out,
  input wire logic i_app_data_oe,
  output logic o_app_data_in,
  output logic o_app_clock_in,
  output logic o_readout_protect_option_bit
);
  import fspc_pkg::*;

  localparam int FSPC_WORDS = 65536;

  logic [7:0] mem [0:FSPC_WORDS-1];
  logic comm_mode;
  logic attached;

  fspc_entry_detect u_entry
  (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_ce(i_ce),
    .i_serial_clk(i_prog_serial_clock),
    .i_tool_reset(i_tool_reset),
    .o_comm_mode(comm_mode),
    .o_tool_attached(attached)
  );

  function automatic logic [1:0] sector_of(input logic [15:0] a);
    if (a >= FSPC_SEC0_BASE)
      sector_of = 2'd0;
    else if (a >= FSPC_SEC1_BASE)
      sector_of = 2'd1;
    else
      sector_of = 2'd2;
  endfunction

  function automatic logic sector_present(input logic [1:0] s, input logic [1:0] sz);
    case (sz)
      FSPC_SIZE_4K: sector_present = (s == 2'd0);
      FSPC_SIZE_8K: sector_present = (s != 2'd2);
      default: sector_present = 1'b1;
    endcase
  endfunction

  // Bus state.
  logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d, b_q, b_d, r_q, r_d;
  logic [7:0] aw_q, aw_d;
  logic [31:0] wd_q, wd_d, rdata_q, rdata_d;
  logic [3:0] ws_q, ws_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  // Register state.
  logic [7:0] fctl_q, fctl_d;
  logic [1:0] guard_q, guard_d;
  logic prot_q, prot_d;
  logic err_q, err_d, done_q, done_d;
  // Erase engine.
  logic busy_q, busy_d, unprot_q, unprot_d;
  logic [15:0] ptr_q, ptr_d, end_q, end_d;
  logic [1:0] sec_q, sec_d;
  // Single memory write port.
  logic mem_we;
  logic [15:0] mem_wa;
  logic [7:0] mem_wd;
  logic [7:0] xr_q, xr_d;

  fspc_mode_t mode;
  assign mode = i_tool_socket ? FSPC_MODE_TOOL : (comm_mode ? FSPC_MODE_ICP : FSPC_MODE_IAP);

  logic wr_go;
  assign wr_go = aw_hold_q && w_hold_q && !b_q;

  always_comb
  begin
    fspc_cmd_t cmd;
    logic [15:0] oa;
    logic [1:0] osec;
    logic allowed;
    cmd = fspc_cmd_t'(wd_q[FSPC_OP_CMD_LSB +: 3]);
    oa = wd_q[FSPC_OP_ADDR_LSB +: 16];
    osec = sector_of(oa);
    allowed = 1'b0;
    aw_hold_d = aw_hold_q;
    w_hold_d = w_hold_q;
    aw_d = aw_q;
    wd_d = wd_q;
    ws_d = ws_q;
    b_d = b_q;
    bresp_d = bresp_q;
    r_d = r_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    fctl_d = fctl_q;
    guard_d = guard_q;
    prot_d = prot_q;
    err_d = err_q;
    done_d = done_q;
    busy_d = busy_q;
    unprot_d = unprot_q;
    ptr_d = ptr_q;
    end_d = end_q;
    sec_d = sec_q;
    mem_we = 1'b0;
    mem_wa = ptr_q;
    mem_wd = 8'hFF;
    xr_d = xr_q;
    if (s_axi_awvalid && !aw_hold_q)
    begin
      aw_hold_d = 1'b1;
      aw_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_hold_q)
    begin
      w_hold_d = 1'b1;
      wd_d = s_axi_wdata;
      ws_d = s_axi_wstrb;
    end
    if (busy_q)
    begin
      // Erase walks one byte a cycle; only the chosen range is touched.
      mem_we = 1'b1;
      ptr_d = ptr_q + 16'd1;
      if (ptr_q == end_q)
      begin
        busy_d = 1'b0;
        done_d = 1'b1;
        if (unprot_q)
        begin
          prot_d = 1'b0;
          unprot_d = 1'b0;
        end
      end
    end
    if (wr_go && !busy_q)
    begin
      aw_hold_d = 1'b0;
      w_hold_d = 1'b0;
      b_d = 1'b1;
      bresp_d = 2'b00;
      case (aw_q[7:2])
        FSPC_IDX_FCTL[5:0]:
          if (ws_q[0])
            fctl_d = wd_q[7:0];
        FSPC_IDX_GUARD[5:0]:
          if (ws_q[0])
          begin
            if (guard_q == 2'd0 && wd_q[7:0] == FSPC_GUARD_KEY1)
              guard_d = 2'd1;
            else if (guard_q == 2'd1 && wd_q[7:0] == FSPC_GUARD_KEY2)
              guard_d = 2'd2;
            else
              guard_d = 2'd0;
          end
        FSPC_IDX_STAT[5:0]:
          if (ws_q[0])
          begin
            err_d = err_q & ~wd_q[0];
            done_d = done_q & ~wd_q[1];
          end
        FSPC_IDX_OPER[5:0]:
        begin
          allowed = (guard_q == 2'd2);
          guard_d = 2'd0;
          if (cmd == FSPC_CMD_PROG || cmd == FSPC_CMD_SECT)
          begin
            allowed = allowed && sector_present(osec, i_flash_size);
            if (mode == FSPC_MODE_IAP && osec == 2'd0)
              allowed = 1'b0;
            if (prot_q && mode != FSPC_MODE_IAP)
              allowed = 1'b0;
          end
          else if (cmd == FSPC_CMD_BULK || cmd == FSPC_CMD_PROT || cmd == FSPC_CMD_UNPROT)
          begin
            if (mode == FSPC_MODE_IAP)
              allowed = 1'b0;
            if (prot_q && cmd == FSPC_CMD_BULK)
              allowed = 1'b0;
          end
          else
          begin
            allowed = 1'b0;
          end
          if (!allowed)
          begin
            err_d = 1'b1;
            bresp_d = 2'b10;
          end
          else
          begin
            case (cmd)
              FSPC_CMD_PROG:
              begin
                // Programming only clears bits, as a real cell does.
                mem_we = 1'b1;
                mem_wa = oa;
                mem_wd = mem[oa] & wd_q[FSPC_OP_DATA_LSB +: 8];
                done_d = 1'b1;
              end
              FSPC_CMD_SECT:
              begin
                busy_d = 1'b1;
                sec_d = osec;
                if (osec == 2'd0)
                begin
                  ptr_d = FSPC_SEC0_BASE;
                  end_d = FSPC_MEM_TOP;
                end
                else if (osec == 2'd1)
                begin
                  ptr_d = FSPC_SEC1_BASE;
                  end_d = FSPC_SEC0_BASE - 16'd1;
                end
                else
                begin
                  ptr_d = 16'h0000;
                  end_d = FSPC_SEC1_BASE - 16'd1;
                end
              end
              FSPC_CMD_PROT:
              begin
                prot_d = 1'b1;
                done_d = 1'b1;
              end
              default:
              begin
                // Bulk erase, and unprotect which always wipes the array first.
                busy_d = 1'b1;
                unprot_d = (cmd == FSPC_CMD_UNPROT);
                ptr_d = 16'h0000;
                end_d = FSPC_MEM_TOP;
              end
            endcase
          end
        end
        default: bresp_d = 2'b10;
      endcase
    end
    if (b_q && s_axi_bready)
      b_d = 1'b0;
    if (s_axi_arvalid && !r_q)
    begin
      r_d = 1'b1;
      rresp_d = 2'b00;
      case (s_axi_araddr[7:2])
        FSPC_IDX_FCTL[5:0]: rdata_d = {24'h0000_00, fctl_q};
        FSPC_IDX_STAT[5:0]: rdata_d = {24'h0000_00, 1'b0, mode, attached, prot_q, busy_q,
                                       done_q, err_q};
        FSPC_IDX_GUARD[5:0]: rdata_d = {30'h0000_0000, guard_q};
        FSPC_IDX_SIZE[5:0]: rdata_d = {30'h0000_0000, i_flash_size};
        default:
        begin
          rdata_d = 32'h0000_0000;
          rresp_d = 2'b10;
        end
      endcase
    end
    if (r_q && s_axi_rready)
      r_d = 1'b0;
    if (i_ext_read_req)
      xr_d = prot_q ? 8'h00 : mem[i_ext_read_addr];
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      b_q <= 1'b0;
      r_q <= 1'b0;
      aw_q <= 8'h00;
      wd_q <= 32'h0000_0000;
      ws_q <= 4'h0;
      bresp_q <= 2'b00;
      rresp_q <= 2'b00;
      rdata_q <= 32'h0000_0000;
      fctl_q <= FSPC_CTRL_RST;
      guard_q <= 2'd0;
      prot_q <= 1'b0;
      err_q <= 1'b0;
      done_q <= 1'b0;
      busy_q <= 1'b0;
      unprot_q <= 1'b0;
      ptr_q <= 16'h0000;
      end_q <= 16'h0000;
      sec_q <= 2'd0;
      xr_q <= 8'h00;
    end
    else if (i_ce)
    begin
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      b_q <= b_d;
      r_q <= r_d;
      aw_q <= aw_d;
      wd_q <= wd_d;
      ws_q <= ws_d;
      bresp_q <= bresp_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      fctl_q <= fctl_d;
      guard_q <= guard_d;
      prot_q <= prot_d;
      err_q <= err_d;
      done_q <= done_d;
      busy_q <= busy_d;
      unprot_q <= unprot_d;
      ptr_q <= ptr_d;
      end_q <= end_d;
      sec_q <= sec_d;
      xr_q <= xr_d;
    end
  end

  // The array has no reset, as flash contents survive reset.
  always_ff @(posedge i_core_clk)
  begin
    if (i_ce && mem_we)
      mem[mem_wa] <= mem_wd;
  end

  // Link data input is synchronised; the application sees idle levels once a tool is on.
  logic [1:0] dsync_q;
  always_ff @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      dsync_q <= 2'b00;
    else if (i_ce)
      dsync_q <= {dsync_q[0], i_prog_serial_data};
  end

  assign o_app_data_in = attached ? 1'b0 : dsync_q[1];
  assign o_app_clock_in = 1'b0;
  assign o_prog_serial_data = i_app_data_out;
  assign o_prog_serial_data_oe = i_app_data_oe && !attached;
  assign o_ext_read_data = xr_q;
  assign o_readout_protect_option_bit = prot_q;
  assign s_axi_awready = !aw_hold_q;
  assign s_axi_wready = !w_hold_q;
  assign s_axi_bvalid = b_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !r_q;
  assign s_axi_rvalid = r_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

endmodule // fspc_top

/* File: sim/fspc_tool_model.sv */
`timescale 1ns/1ps
module fspc_tool_model
(
  output logic o_serial_clock,
  output logic o_tool_reset,
  output logic o_serial_data
);
  initial
  begin
    o_serial_clock = 1'b0;
    o_tool_reset = 1'b0;
    o_serial_data = 1'b0;
  end
  // The link clock stands low outside the entry frame, as a real tool leaves it.
  task automatic enter();
    #3 o_tool_reset = 1'b1;
    repeat (36)
    begin
      #80 o_serial_clock = 1'b1;
      o_serial_data = ~o_serial_data;
      #80 o_serial_clock = 1'b0;
    end
    #80 o_tool_reset = 1'b0;
    o_serial_data = ~o_serial_data;
  endtask
endmodule // fspc_tool_model

/* File: sim/fspc_top_asserts.sv */
`timescale 1ns/1ps
module fspc_top_asserts
(
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic i_ext_read_req,
  input wire logic [7:0] o_ext_read_data,
  input wire logic i_tool_reset,
  input wire logic o_prog_serial_data_oe,
  input wire logic o_app_data_in,
  input wire logic o_readout_protect_option_bit
);
  default clocking @(posedge i_core_clk);
  endclocking
  default disable iff (i_sys_rst);
  // Cycles since the last write response, saturating. Unprotect wipes the whole array one
  // byte a cycle before protection may fall; the margin below 65536 covers the handshake.
  logic [16:0] quiet_q;
  always_ff @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      quiet_q <= 17'h0_0000;
    else if (s_axi_bvalid)
      quiet_q <= 17'h0_0000;
    else if (!quiet_q[16])
      quiet_q <= quiet_q + 17'h0_0001;
  end
  sequence s_prot_read;
    o_readout_protect_option_bit && i_ext_read_req ##1 o_readout_protect_option_bit;
  endsequence
  sequence s_tool_held;
    i_tool_reset [*4];
  endsequence
  property p_rdata_stands;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_read_answer;
    s_axi_arvalid && s_axi_arready && !s_axi_rvalid |=> s_axi_rvalid;
  endproperty
  property p_write_after_take;
    $rose(s_axi_bvalid) |-> !$past(s_axi_awready) && !$past(s_axi_wready);
  endproperty
  property p_rresp_legal;
    s_axi_rvalid |-> s_axi_rresp == 2'h0 || s_axi_rresp == 2'h2;
  endproperty
  property p_pins_hidden;
    s_tool_held |-> ##1 !o_prog_serial_data_oe && !o_app_data_in;
  endproperty
  property p_unprot_late;
    $fell(o_readout_protect_option_bit) |-> quiet_q >= 17'h0_FF00;
  endproperty
  a_bvalid_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_rdata_stands: assert property (p_rdata_stands)
    else $error("read response changed early");
  a_read_answer: assert property (p_read_answer)
    else $error("read answer late");
  a_write_after_take: assert property (p_write_after_take)
    else $error("write answered before capture");
  a_rresp_legal: assert property (p_rresp_legal)
    else $error("bad read response code");
  a_prot_read_zero: assert property (s_prot_read |-> o_ext_read_data == 8'h00)
    else $error("protected data leaked");
  a_pins_hidden: assert property (p_pins_hidden)
    else $error("link pins still given to application");
  a_unprot_late: assert property (p_unprot_late)
    else $error("protection lifted before the array was wiped");
endmodule // fspc_top_asserts
bind fspc_top fspc_top_asserts u_chk (.*);

/* File: sim/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import fspc_pkg::*;
  logic i_core_clk, i_sys_rst, i_ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic i_tool_socket, i_ext_read_req, i_prog_serial_clock, i_tool_reset, i_prog_serial_data;
  logic o_prog_serial_data, o_prog_serial_data_oe, i_app_data_out, i_app_data_oe, o_app_data_in;
  logic o_app_clock_in, o_readout_protect_option_bit;
  logic [7:0] s_axi_awaddr, s_axi_araddr, o_ext_read_data;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, i_flash_size;
  logic [15:0] i_ext_read_addr;
  int errors = 0;
  int compares = 0;
  int cycles = 0;
  fspc_top dut (.*);
  fspc_tool_model tool (.o_serial_clock(i_prog_serial_clock), .o_tool_reset(i_tool_reset),
    .o_serial_data(i_prog_serial_data));
  initial
  begin
    i_core_clk = 1'b0;
    forever #2.5 i_core_clk = ~i_core_clk;
  end
  // Longest path is one unprotect erase of the whole array plus three sector erases; the ceiling leaves slack.
  always @(posedge i_core_clk)
  begin
    cycles = cycles + 1;
    if (cycles == 95000)
    begin
      errors = errors + 1;
      conclude();
    end
  end
  task automatic conclude();
    if (errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] er);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= {idx[5:0], 2'h0};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw && w))
    begin
      @(negedge i_core_clk);
      aw = aw | (s_axi_awvalid & s_axi_awready);
      w = w | (s_axi_wvalid & s_axi_wready);
      @(posedge i_core_clk);
      s_axi_awvalid <= ~aw;
      s_axi_wvalid <= ~w;
    end
    do @(negedge i_core_clk); while (s_axi_bvalid !== 1'b1);
    @(posedge i_core_clk);
    s_axi_bready <= 1'b1;
    @(negedge i_core_clk);
    chk({30'h0, s_axi_bresp}, {30'h0, er});
    @(posedge i_core_clk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] idx, output logic [31:0] d, input logic [1:0] er);
    s_axi_araddr <= {idx[5:0], 2'h0};
    s_axi_arvalid <= 1'b1;
    do @(negedge i_core_clk); while (s_axi_arready !== 1'b1);
    @(posedge i_core_clk);
    s_axi_arvalid <= 1'b0;
    do @(negedge i_core_clk); while (s_axi_rvalid !== 1'b1);
    @(posedge i_core_clk);
    s_axi_rready <= 1'b1;
    @(negedge i_core_clk);
    d = s_axi_rdata;
    chk({30'h0, s_axi_rresp}, {30'h0, er});
    @(posedge i_core_clk);
    s_axi_rready <= 1'b0;
  endtask
  task automatic op(input fspc_cmd_t c, input logic [15:0] a, input logic [7:0] d,
    input logic [1:0] er);
    wr(FSPC_IDX_GUARD, {24'h00_0000, FSPC_GUARD_KEY1}, 2'h0);
    wr(FSPC_IDX_GUARD, {24'h00_0000, FSPC_GUARD_KEY2}, 2'h0);
    wr(FSPC_IDX_OPER, {d, a, 5'h00, c}, er);
  endtask
  task automatic xrd(input logic [15:0] a, output logic [31:0] d);
    i_ext_read_req <= 1'b1;
    i_ext_read_addr <= a;
    @(posedge i_core_clk);
    i_ext_read_req <= 1'b0;
    @(negedge i_core_clk);
    d = {24'h00_0000, o_ext_read_data};
    @(posedge i_core_clk);
  endtask
  initial
  begin
    logic [31:0] g;
    i_sys_rst = 1'b1;
    i_ce = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    i_flash_size = FSPC_SIZE_BIG;
    i_tool_socket = 1'b0;
    i_ext_read_req = 1'b0;
    i_ext_read_addr = 16'h0000;
    i_app_data_out = 1'b1;
    i_app_data_oe = 1'b1;
    repeat (6) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_core_clk);
    rd(FSPC_IDX_FCTL, g, 2'h0);
    chk({24'h00_0000, g[7:0]}, {24'h00_0000, FSPC_CTRL_RST});
    wr(FSPC_IDX_FCTL, 32'h0000_00A5, 2'h0);
    rd(FSPC_IDX_FCTL, g, 2'h0);
    chk({24'h00_0000, g[7:0]}, 32'h0000_00A5);
    rd(8'h3F, g, 2'h2);
    @(negedge i_core_clk);
    chk({30'h0, o_prog_serial_data_oe, o_prog_serial_data}, 32'h0000_0003);
    @(posedge i_core_clk);
    wr(FSPC_IDX_OPER, {8'h22, FSPC_SEC1_BASE, 5'h00, FSPC_CMD_PROG}, 2'h2);
    op(FSPC_CMD_SECT, FSPC_SEC1_BASE, 8'h00, 2'h0);
    op(FSPC_CMD_SECT, FSPC_SEC0_BASE, 8'h00, 2'h2);
    op(FSPC_CMD_PROG, FSPC_SEC0_BASE, 8'h11, 2'h2);
    op(FSPC_CMD_PROG, FSPC_SEC1_BASE, 8'h22, 2'h0);
    op(FSPC_CMD_BULK, 16'h0000, 8'h00, 2'h2);
    xrd(FSPC_SEC1_BASE, g);
    chk(g, 32'h0000_0022);
    i_flash_size <= FSPC_SIZE_4K;
    op(FSPC_CMD_PROG, FSPC_SEC1_BASE, 8'h33, 2'h2);
    i_flash_size <= FSPC_SIZE_BIG;
    tool.enter();
    repeat (4) @(posedge i_core_clk);
    rd(FSPC_IDX_STAT, g, 2'h0);
    chk({29'h0, g[6:4]}, {29'h0, FSPC_MODE_ICP, 1'b1});
    @(negedge i_core_clk);
    chk({29'h0, o_prog_serial_data_oe, o_app_data_in, o_app_clock_in}, 32'h0000_0000);
    @(posedge i_core_clk);
    op(FSPC_CMD_SECT, FSPC_SEC0_BASE, 8'h00, 2'h0);
    op(FSPC_CMD_PROG, FSPC_SEC0_BASE, 8'h11, 2'h0);
    op(FSPC_CMD_SECT, FSPC_SEC1_BASE, 8'h00, 2'h0);
    xrd(FSPC_MEM_TOP - 16'h0FFF, g);
    chk(g, 32'h0000_0011);
    op(FSPC_CMD_PROT, 16'h0000, 8'h00, 2'h0);
    rd(FSPC_IDX_STAT, g, 2'h0);
    chk({30'h0, g[3], o_readout_protect_option_bit}, 32'h0000_0003);
    xrd(FSPC_SEC0_BASE, g);
    chk(g, 32'h0000_0000);
    op(FSPC_CMD_PROG, FSPC_SEC1_BASE, 8'h00, 2'h2);
    op(FSPC_CMD_BULK, 16'h0000, 8'h00, 2'h2);
    op(FSPC_CMD_UNPROT, 16'h0000, 8'h00, 2'h0);
    rd(FSPC_IDX_STAT, g, 2'h0);
    chk({30'h0, g[3:2]}, 32'h0000_0003);
    while (g[2])
      rd(FSPC_IDX_STAT, g, 2'h0);
    chk({31'h0, g[3]}, 32'h0000_0000);
    xrd(FSPC_SEC0_BASE, g);
    chk({31'h0, g !== 32'h0000_0011}, 32'h0000_0001);
    i_tool_socket <= 1'b1;
    @(posedge i_core_clk);
    rd(FSPC_IDX_STAT, g, 2'h0);
    chk({30'h0, g[6:5]}, {30'h0, FSPC_MODE_TOOL});
    conclude();
  end
endmodule // testbench
